/* rtl/lcd_pkg.sv */
// Constants and types shared by the display memory command block.
package lcd_pkg;
    localparam int DATA_W   = 8;
    localparam int COL_W    = 7;
    localparam int PAGE_W   = 2;
    localparam int LINE_W   = 5;
    localparam int HALVES   = 2;
    localparam int PAGE_COUNT = 4;
    localparam int COL_COUNT  = 81;
    localparam logic [COL_W-1:0]  COL_LAST    = 7'h50;
    localparam logic [COL_W-1:0]  COL_ONE     = 7'h01;
    localparam logic [PAGE_W-1:0] PAGE_RESET  = 2'h3;
    localparam logic [LINE_W-1:0] LINE_RESET  = 5'h00;
    localparam logic [DATA_W-1:0] CMD_RMW     = 8'hE0;
    localparam logic [DATA_W-1:0] CMD_END     = 8'hEE;
    localparam logic [DATA_W-1:0] CMD_SWRESET = 8'hE2;
    localparam logic [DATA_W-1:0] SET_PAGE_MASK = 8'hFC;
    localparam logic [DATA_W-1:0] SET_PAGE_BASE = 8'hB8;
    localparam logic [DATA_W-1:0] SET_LINE_MASK = 8'hE0;
    localparam logic [DATA_W-1:0] SET_LINE_BASE = 8'hC0;
    localparam logic [5:0]        STATUS_LOW    = 6'h00;
    localparam int STATUS_BUSY_BIT = 7;
    localparam int FIFO_DEPTH      = 4;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int EXEC_TIME_NS    = 100;
    localparam int EXEC_CYCLES     = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W           = 3;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_COMMAND,
        OP_RELOAD
    } op_t;

    typedef struct packed {
        op_t               op;
        logic [HALVES-1:0] halves;
        logic [DATA_W-1:0] value;
    } entry_t;

    localparam int ENTRY_W = $bits(entry_t);
endpackage

/* rtl/fifo_if.sv */
// Valid and ready stream between the pin front end, the queue and the executor.
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 12);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport sink     (input valid, input data, output ready);
    modport source   (output valid, output data, input ready);
    modport producer (output valid, output data, input ready);
    modport consumer (input valid, input data, output ready);
endinterface

/* rtl/data_fifo.sv */
// Small flip-flop queue with honest full and empty; depth must be a power of two.
`timescale 1ns/1ps
module data_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input  wire logic clk,
    input  wire logic rst,
    fifo_if.sink      fill,
    fifo_if.source    drain
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [AW-1:0]               rd_ptr;
        logic [AW-1:0]               wr_ptr;
        logic [AW:0]                 count;
    } fifo_state_t;

    fifo_state_t state_ff;
    fifo_state_t nxt_state;
    logic        push;
    logic        pop;

    assign fill.ready  = (state_ff.count != (AW+1)'(DEPTH));
    assign drain.valid = (state_ff.count != '0);
    assign drain.data  = state_ff.slot[state_ff.rd_ptr];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    always_comb begin
        nxt_state = state_ff;
        if (push) begin
            nxt_state.slot[state_ff.wr_ptr] = fill.data;
            nxt_state.wr_ptr = state_ff.wr_ptr + AW'(1);
        end
        if (pop) begin
            nxt_state.rd_ptr = state_ff.rd_ptr + AW'(1);
        end
        nxt_state.count = state_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

/* rtl/lcd_panel_ctrl.sv */
// Display memory access and command execution for both halves of the panel.
//
// Notes on behaviour
// (R01) Data write stores byte at page, column.
// (R02) Data write advances column by one.
// (R03) Host writes data with select high.
// (R04) Data read first presents output latch.
// (R05) Then latch loads byte at page, column.
// (R06) Normal mode read advances column last.
// (R07) Host issues one dummy read after addressing.
// (R08) Writes bypass latch, no dummy write.
// (R09) Host reads data with select high.
// (R10) Command E0 enters mode, saves column.
// (R11) In that mode reads keep column.
// (R12) Other registers still change in mode.
// (R13) Command EE returns to normal mode.
// (R14) Command EE restores the saved column.
// (R15) Host writes commands with select low.
// (R16) Command E2 is a register reset.
// (R17) Register reset clears start line.
// (R18) Register reset sets page to three.
// (R19) Register reset keeps memory, other registers.
// (R20) Host still needs the hardware reset.
// (R21) First select left half, second right.
// (R22) Busy rejects all but status read.
// (R23) Column register is seven bits wide.
// (R24) Column never increments past 50H.
// (R25) Page register is two bits wide.
// (R26) Command EE outside mode does nothing.
`timescale 1ns/1ps
module lcd_panel_ctrl (
    input  wire logic                                     CLK_SYS,
    input  wire logic                                     RESET,
    input  wire logic                                     DATA_OR_INSTRUCTION_SELECT,
    input  wire logic                                     LEFT_HALF_SELECT,
    input  wire logic                                     RIGHT_HALF_SELECT,
    input  wire logic                                     READ_STROBE_N,
    input  wire logic                                     WRITE_STROBE_N,
    input  wire logic [lcd_pkg::DATA_W-1:0]               PARALLEL_DATA_LINES_IN,
    output logic      [lcd_pkg::DATA_W-1:0]               PARALLEL_DATA_LINES_OUT,
    output logic                                          PARALLEL_DATA_LINES_OE,
    output logic                                          BUSY,
    output logic      [lcd_pkg::HALVES-1:0][lcd_pkg::COL_W-1:0]  COLUMN_ADDR,
    output logic      [lcd_pkg::HALVES-1:0][lcd_pkg::PAGE_W-1:0] PAGE_ADDR,
    output logic      [lcd_pkg::HALVES-1:0][lcd_pkg::LINE_W-1:0] START_LINE,
    output logic      [lcd_pkg::HALVES-1:0]               RMW_ACTIVE
);
    typedef struct packed {
        logic [lcd_pkg::HALVES-1:0][lcd_pkg::PAGE_COUNT-1:0][lcd_pkg::COL_COUNT-1:0][lcd_pkg::DATA_W-1:0] mem;
        logic [lcd_pkg::HALVES-1:0][lcd_pkg::DATA_W-1:0] latch;
        logic [lcd_pkg::HALVES-1:0][lcd_pkg::COL_W-1:0]  col;
        logic [lcd_pkg::HALVES-1:0][lcd_pkg::COL_W-1:0]  saved_col;
        logic [lcd_pkg::HALVES-1:0][lcd_pkg::PAGE_W-1:0] page;
        logic [lcd_pkg::HALVES-1:0][lcd_pkg::LINE_W-1:0] line;
        logic [lcd_pkg::HALVES-1:0]                      rmw;
        logic                                            rd_n_q;
        logic                                            wr_n_q;
        logic                                            a0_q;
        logic [lcd_pkg::HALVES-1:0]                      cs_q;
        logic [lcd_pkg::DATA_W-1:0]                      bus_q;
        logic                                            rd_taken;
        logic [lcd_pkg::HALVES-1:0]                      rd_halves;
        logic [lcd_pkg::GAP_W-1:0]                       gap;
        logic [lcd_pkg::DATA_W-1:0]                      dout;
        logic                                            oe;
        logic                                            busy;
    } core_state_t;

    core_state_t                  state_ff;
    core_state_t                  nxt_state;
    lcd_pkg::entry_t              push_entry;
    lcd_pkg::entry_t              ex_entry;
    logic                         push_req;
    logic                         ex_pop;
    logic                         busy_now;
    logic                         pending;
    logic                         rd_fall;
    logic                         rd_rise;
    logic                         wr_rise;
    logic                         rd_data_take;
    logic [lcd_pkg::HALVES-1:0]   cs_now;
    logic [lcd_pkg::HALVES-1:0]   rd_sel;

    fifo_if #(.WIDTH(lcd_pkg::ENTRY_W)) fill_if ();
    fifo_if #(.WIDTH(lcd_pkg::ENTRY_W)) drain_if ();

    // The queue absorbs bursts; when it is full the front end refuses new writes and data reads.
    data_fifo #(
        .WIDTH (lcd_pkg::ENTRY_W),
        .DEPTH (lcd_pkg::FIFO_DEPTH)
    ) data_fifo_i (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .fill  (fill_if.sink),
        .drain (drain_if.source)
    );

    assign cs_now   = {RIGHT_HALF_SELECT, LEFT_HALF_SELECT};          // [R21]
    assign rd_sel   = LEFT_HALF_SELECT ? 2'h1 : 2'h2;                 // [R21]
    assign busy_now = !fill_if.ready;
    assign pending  = drain_if.valid || (state_ff.gap != '0);
    assign rd_fall  = state_ff.rd_n_q && !READ_STROBE_N && WRITE_STROBE_N;
    assign rd_rise  = !state_ff.rd_n_q && READ_STROBE_N;
    assign wr_rise  = !state_ff.wr_n_q && WRITE_STROBE_N && state_ff.rd_n_q;
    // A data read while busy is refused, so no reload is queued for it.
    assign rd_data_take = rd_fall && DATA_OR_INSTRUCTION_SELECT && (cs_now != '0) && !busy_now; // [R09] [R22]

    always_comb begin
        push_entry = '0;
        push_req   = 1'b0;
        if (wr_rise && (state_ff.cs_q != '0)) begin
            push_req          = 1'b1;
            push_entry.op     = state_ff.a0_q ? lcd_pkg::OP_WRITE : lcd_pkg::OP_COMMAND; // [R03] [R15]
            push_entry.halves = state_ff.cs_q;                                          // [R21]
            push_entry.value  = state_ff.bus_q;
        end else if (rd_rise && state_ff.rd_taken) begin
            push_req          = 1'b1;
            push_entry.op     = lcd_pkg::OP_RELOAD;                                     // [R05]
            push_entry.halves = state_ff.rd_halves;
        end
    end

    assign fill_if.valid  = push_req;                                   // [R22]
    assign fill_if.data   = push_entry;
    assign drain_if.ready = (state_ff.gap == '0);
    assign ex_pop         = drain_if.valid && drain_if.ready;
    assign ex_entry       = lcd_pkg::entry_t'(drain_if.data);

    always_comb begin
        nxt_state        = state_ff;
        nxt_state.rd_n_q = READ_STROBE_N;
        nxt_state.wr_n_q = WRITE_STROBE_N;
        nxt_state.a0_q   = DATA_OR_INSTRUCTION_SELECT;
        nxt_state.cs_q   = cs_now;
        nxt_state.bus_q  = PARALLEL_DATA_LINES_IN;
        nxt_state.busy   = busy_now;
        if (rd_fall && !DATA_OR_INSTRUCTION_SELECT && (cs_now != '0)) begin
            nxt_state.dout = {busy_now, pending, lcd_pkg::STATUS_LOW};  // [R22]
            nxt_state.oe   = 1'b1;
        end else if (rd_data_take) begin
            nxt_state.dout      = rd_sel[0] ? state_ff.latch[0] : state_ff.latch[1]; // [R04]
            nxt_state.oe        = 1'b1;
            nxt_state.rd_taken  = 1'b1;
            nxt_state.rd_halves = rd_sel;
        end
        if (rd_rise) begin
            nxt_state.oe       = 1'b0;
            nxt_state.rd_taken = 1'b0;
        end
        if (ex_pop) begin
            nxt_state.gap = lcd_pkg::GAP_W'(lcd_pkg::EXEC_CYCLES - 1);
        end else if (state_ff.gap != '0) begin
            nxt_state.gap = state_ff.gap - lcd_pkg::GAP_W'(1);
        end
        for (int h = 0; h < lcd_pkg::HALVES; h++) begin
            if (ex_pop && ex_entry.halves[h]) begin
                case (ex_entry.op)
                    lcd_pkg::OP_WRITE: begin
                        // Writes go straight to the cells and leave the latch alone.
                        nxt_state.mem[h][state_ff.page[h]][state_ff.col[h]] = ex_entry.value; // [R01] [R08] [R25]
                        if (state_ff.col[h] < lcd_pkg::COL_LAST) begin
                            nxt_state.col[h] = state_ff.col[h] + lcd_pkg::COL_ONE; // [R02] [R11] [R24]
                        end
                    end
                    lcd_pkg::OP_RELOAD: begin
                        nxt_state.latch[h] = state_ff.mem[h][state_ff.page[h]][state_ff.col[h]]; // [R05]
                        if (!state_ff.rmw[h] && (state_ff.col[h] < lcd_pkg::COL_LAST)) begin
                            nxt_state.col[h] = state_ff.col[h] + lcd_pkg::COL_ONE; // [R06] [R11] [R24]
                        end
                    end
                    lcd_pkg::OP_COMMAND: begin
                        if (ex_entry.value == lcd_pkg::CMD_RMW) begin
                            nxt_state.rmw[h]       = 1'b1;                 // [R10]
                            nxt_state.saved_col[h] = state_ff.col[h];      // [R10]
                        end else if (ex_entry.value == lcd_pkg::CMD_END) begin
                            if (state_ff.rmw[h]) begin                     // [R26]
                                nxt_state.rmw[h] = 1'b0;                   // [R13]
                                nxt_state.col[h] = state_ff.saved_col[h];  // [R14]
                            end
                        end else if (ex_entry.value == lcd_pkg::CMD_SWRESET) begin
                            nxt_state.line[h] = lcd_pkg::LINE_RESET;       // [R16] [R17] [R19]
                            nxt_state.page[h] = lcd_pkg::PAGE_RESET;       // [R18]
                        end else if ((ex_entry.value & lcd_pkg::SET_PAGE_MASK) == lcd_pkg::SET_PAGE_BASE) begin
                            nxt_state.page[h] = ex_entry.value[lcd_pkg::PAGE_W-1:0]; // [R12] [R25]
                        end else if ((ex_entry.value & lcd_pkg::SET_LINE_MASK) == lcd_pkg::SET_LINE_BASE) begin
                            nxt_state.line[h] = ex_entry.value[lcd_pkg::LINE_W-1:0]; // [R12]
                        end else if ((ex_entry.value <= {1'b0, lcd_pkg::COL_LAST}) && !state_ff.rmw[h]) begin
                            // The column command is ignored in the mode so the restore stays meaningful.
                            nxt_state.col[h] = ex_entry.value[lcd_pkg::COL_W-1:0]; // [R23] [R24]
                        end
                    end
                    default: begin
                        nxt_state.gap = state_ff.gap;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_ff        <= '0;
            state_ff.rd_n_q <= 1'b1;
            state_ff.wr_n_q <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign PARALLEL_DATA_LINES_OUT = state_ff.dout;
    assign PARALLEL_DATA_LINES_OE  = state_ff.oe;
    assign BUSY                    = state_ff.busy;
    assign COLUMN_ADDR             = state_ff.col;
    assign PAGE_ADDR               = state_ff.page;
    assign START_LINE              = state_ff.line;
    assign RMW_ACTIVE              = state_ff.rmw;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    logic ex_write0;
    logic ex_reload0;
    logic ex_cmd0;
    logic ex_cmd1;
    assign ex_write0  = ex_pop && ex_entry.halves[0] && (ex_entry.op == lcd_pkg::OP_WRITE);
    assign ex_reload0 = ex_pop && ex_entry.halves[0] && (ex_entry.op == lcd_pkg::OP_RELOAD);
    assign ex_cmd0    = ex_pop && ex_entry.halves[0] && (ex_entry.op == lcd_pkg::OP_COMMAND);
    assign ex_cmd1    = ex_pop && ex_entry.halves[1] && (ex_entry.op == lcd_pkg::OP_COMMAND);

    property p_write_stores;
        ex_write0 |=> state_ff.mem[0][$past(state_ff.page[0])][$past(state_ff.col[0])] == $past(ex_entry.value);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("Write did not store byte."); // [R01]

    property p_write_advance;
        ex_write0 && (state_ff.col[0] < lcd_pkg::COL_LAST) |=> state_ff.col[0] == $past(state_ff.col[0]) + lcd_pkg::COL_ONE;
    endproperty
    a_write_advance: assert property (p_write_advance) else $error("Write did not advance column."); // [R02]

    property p_read_presents;
        rd_data_take && LEFT_HALF_SELECT |=> PARALLEL_DATA_LINES_OE && (PARALLEL_DATA_LINES_OUT == $past(state_ff.latch[0]));
    endproperty
    a_read_presents: assert property (p_read_presents) else $error("Read did not present latch."); // [R04]

    property p_reload;
        ex_reload0 |=> state_ff.latch[0] == $past(state_ff.mem[0][state_ff.page[0]][state_ff.col[0]]);
    endproperty
    a_reload: assert property (p_reload) else $error("Latch not reloaded from memory."); // [R05]

    property p_read_advance;
        ex_reload0 && !state_ff.rmw[0] && (state_ff.col[0] < lcd_pkg::COL_LAST)
            |=> state_ff.col[0] == $past(state_ff.col[0]) + lcd_pkg::COL_ONE;
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("Normal read did not advance column."); // [R06]

    property p_write_keeps_latch;
        ex_write0 |=> $stable(state_ff.latch[0]);
    endproperty
    a_write_keeps_latch: assert property (p_write_keeps_latch) else $error("Write disturbed latch."); // [R08]

    property p_rmw_enter;
        ex_cmd0 && (ex_entry.value == lcd_pkg::CMD_RMW) |=> state_ff.rmw[0] && (state_ff.saved_col[0] == $past(state_ff.col[0]));
    endproperty
    a_rmw_enter: assert property (p_rmw_enter) else $error("Mode entry did not save column."); // [R10]

    property p_rmw_read_hold;
        ex_reload0 && state_ff.rmw[0] |=> $stable(state_ff.col[0]) [*2];
    endproperty
    a_rmw_read_hold: assert property (p_rmw_read_hold) else $error("Read moved column in mode."); // [R11]

    property p_end_restore;
        ex_cmd0 && (ex_entry.value == lcd_pkg::CMD_END) && state_ff.rmw[0]
            |=> !state_ff.rmw[0] && (state_ff.col[0] == $past(state_ff.saved_col[0]));
    endproperty
    a_end_restore: assert property (p_end_restore) else $error("End did not restore column."); // [R14]

    property p_swreset;
        ex_cmd1 && (ex_entry.value == lcd_pkg::CMD_SWRESET) |=> (state_ff.line[1] == lcd_pkg::LINE_RESET)
            && (state_ff.page[1] == lcd_pkg::PAGE_RESET) && $stable(state_ff.col[1]) && $stable(state_ff.mem);
    endproperty
    a_swreset: assert property (p_swreset) else $error("Software reset effect wrong."); // [R18]

    property p_end_idle;
        ex_cmd0 && (ex_entry.value == lcd_pkg::CMD_END) && !state_ff.rmw[0] |=> $stable(state_ff.col[0]) && !state_ff.rmw[0];
    endproperty
    a_end_idle: assert property (p_end_idle) else $error("End outside mode changed state."); // [R26]

    property p_status_busy;
        rd_fall && !DATA_OR_INSTRUCTION_SELECT && (cs_now != '0)
            |=> PARALLEL_DATA_LINES_OUT[lcd_pkg::STATUS_BUSY_BIT] == $past(busy_now);
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("Status bit 7 does not show busy."); // [R22]

    property p_col_clamp;
        state_ff.col[0] <= lcd_pkg::COL_LAST && state_ff.col[1] <= lcd_pkg::COL_LAST;
    endproperty
    a_col_clamp: assert property (p_col_clamp) else $error("Column beyond last address."); // [R24]

    property p_left_only;
        ex_pop && (ex_entry.halves == 2'h1) |=> $stable(state_ff.col[1]) && $stable(state_ff.latch[1]);
    endproperty
    a_left_only: assert property (p_left_only) else $error("Left access touched right half."); // [R21]

    property p_rmw_page;
        ex_cmd0 && state_ff.rmw[0] && ((ex_entry.value & lcd_pkg::SET_PAGE_MASK) == lcd_pkg::SET_PAGE_BASE)
            |=> state_ff.page[0] == $past(ex_entry.value[lcd_pkg::PAGE_W-1:0]);
    endproperty
    a_rmw_page: assert property (p_rmw_page) else $error("Page not set in mode."); // [R12]

    property p_rmw_col_frozen;
        ex_cmd0 && state_ff.rmw[0] && (ex_entry.value <= {1'b0, lcd_pkg::COL_LAST}) |=> $stable(state_ff.col[0]);
    endproperty
    a_rmw_col_frozen: assert property (p_rmw_col_frozen) else $error("Column command moved column in mode."); // [R12]

    property p_set_col;
        ex_cmd0 && !state_ff.rmw[0] && (ex_entry.value <= {1'b0, lcd_pkg::COL_LAST})
            |=> state_ff.col[0] == $past(ex_entry.value[lcd_pkg::COL_W-1:0]);
    endproperty
    a_set_col: assert property (p_set_col) else $error("Column command not applied."); // [R23]

    property p_end_leaves;
        ex_cmd0 && (ex_entry.value == lcd_pkg::CMD_END) |=> !state_ff.rmw[0];
    endproperty
    a_end_leaves: assert property (p_end_leaves) else $error("End left the mode active."); // [R13]

    // A refused access must not slip into a full queue behind the host's back.
    property p_full_refuses;
        busy_now && push_req && !ex_pop |=> busy_now;
    endproperty
    a_full_refuses: assert property (p_full_refuses) else $error("Full queue took a refused access."); // [R22]

    property p_oe_hold;
        PARALLEL_DATA_LINES_OE && !rd_rise |=> PARALLEL_DATA_LINES_OE;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("Read data dropped before strobe release."); // [R04]

    property p_oe_release;
        rd_rise |=> !PARALLEL_DATA_LINES_OE;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("Bus still driven after strobe release."); // [R04]

    c_rmw_cycle: cover property (ex_cmd0 && (ex_entry.value == lcd_pkg::CMD_RMW) ##[1:400] ex_cmd0 && (ex_entry.value == lcd_pkg::CMD_END));
    c_queue_full: cover property (busy_now && push_req);
    c_dummy_read: cover property (rd_data_take ##[1:200] rd_data_take);
    c_swreset: cover property (ex_cmd1 && (ex_entry.value == lcd_pkg::CMD_SWRESET));
endmodule

/* sim/host_model.sv */
// Host microcontroller model driving the parallel pins of the display controller.
`timescale 1ns/1ps
module host_model (
    input  wire logic                       clk,
    input  wire logic [lcd_pkg::DATA_W-1:0] dout,
    input  wire logic                       doe,
    output logic                            a0,
    output logic                            left_sel,
    output logic                            right_sel,
    output logic                            rd_n,
    output logic                            wr_n,
    output logic [lcd_pkg::DATA_W-1:0]      din
);
    initial begin
        a0 = 1'b0;
        left_sel = 1'b0;
        right_sel = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        din = 8'h00;
    end

    // Data and selects stay put through the low phase and the first high sample of the strobe.
    task automatic wr(input logic dat, input logic [1:0] sel, input logic [7:0] val);
        @(posedge clk);
        a0 <= dat;
        {right_sel, left_sel} <= sel;
        din <= val;
        wr_n <= 1'b0;
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
        // A released bus must not keep showing the last byte.
        din <= ~val;
        {right_sel, left_sel} <= 2'b00;
    endtask

    // The first read after addressing returns the stale latch, so callers treat it as dummy.
    task automatic rd(input logic dat, input logic [1:0] sel, output logic [7:0] val, output logic oe);
        @(posedge clk);
        a0 <= dat;
        {right_sel, left_sel} <= sel;
        rd_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        val = dout;
        oe = doe;
        @(posedge clk);
        rd_n <= 1'b1;
        @(posedge clk);
        {right_sel, left_sel} <= 2'b00;
    endtask
endmodule

/* sim/lcd_display_memory_commands_tb.sv */
// Self-checking bench for the display memory command block.
`timescale 1ns/1ps
module lcd_display_memory_commands_tb;
    logic                                     clk_sys;
    logic                                     reset;
    logic                                     a0, lsel, rsel, rd_n, wr_n;
    logic [7:0]                               din, dout, rdv;
    logic                                     doe, busy, rdoe, seen_busy;
    logic [1:0][6:0]                          col;
    logic [1:0][1:0]                          page;
    logic [1:0][4:0]                          line;
    logic [1:0]                               rmw;
    int                                       miscompares, n_tests, cycles;

    lcd_panel_ctrl lcd_panel_ctrl_i (.CLK_SYS(clk_sys), .RESET(reset), .DATA_OR_INSTRUCTION_SELECT(a0),
        .LEFT_HALF_SELECT(lsel), .RIGHT_HALF_SELECT(rsel), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
        .PARALLEL_DATA_LINES_IN(din), .PARALLEL_DATA_LINES_OUT(dout), .PARALLEL_DATA_LINES_OE(doe),
        .BUSY(busy), .COLUMN_ADDR(col), .PAGE_ADDR(page), .START_LINE(line), .RMW_ACTIVE(rmw));
    host_model host_model_i (.clk(clk_sys), .dout(dout), .doe(doe), .a0(a0), .left_sel(lsel),
        .right_sel(rsel), .rd_n(rd_n), .wr_n(wr_n), .din(din));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (busy === 1'b1) seen_busy <= 1'b1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Poll status until nothing is pending; a stuck queue shows up as a status mismatch.
    task automatic idle();
        for (int i = 0; i < 20; i++) begin
            host_model_i.rd(1'b0, 2'b01, rdv, rdoe);
            if (rdv[6] === 1'b0) return;
        end
        chk(rdv, 8'h00);
    endtask

    task automatic put(input logic dat, input logic [1:0] sel, input logic [7:0] val);
        host_model_i.wr(dat, sel, val);
        idle();
    endtask

    task automatic get(input logic [7:0] exp);
        host_model_i.rd(1'b1, 2'b01, rdv, rdoe);
        chk(8'(rdoe), 8'h01);
        chk(rdv, exp);
        idle();
    endtask

    initial begin
        miscompares = 0;
        n_tests = 0;
        cycles = 0;
        seen_busy = 1'b0;
        reset = 1'b1;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 3; i++) put(1'b1, 2'b01, 8'hA1 + 8'(i));
        chk(8'(col[0]), 8'h03);
        put(1'b0, 2'b01, 8'h00);
        get(8'h00);
        chk(8'(col[0]), 8'h01);
        get(8'hA1);
        get(8'hA2);
        put(1'b0, 2'b01, lcd_pkg::CMD_RMW);
        chk(8'(rmw[0]), 8'h01);
        get(8'hA3);
        chk(8'(col[0]), 8'h03);
        put(1'b1, 2'b01, 8'h5A);
        chk(8'(col[0]), 8'h04);
        put(1'b0, 2'b01, 8'hB9);
        put(1'b0, 2'b01, 8'h00);
        chk(8'(page[0]), 8'h01);
        chk(8'(col[0]), 8'h04);
        put(1'b0, 2'b01, lcd_pkg::CMD_END);
        chk(8'(rmw[0]), 8'h00);
        chk(8'(col[0]), 8'h03);
        put(1'b0, 2'b01, lcd_pkg::CMD_END);
        chk(8'(col[0]), 8'h03);
        chk(8'(page[0]), 8'h01);
        put(1'b0, 2'b10, 8'hC5);
        put(1'b0, 2'b10, 8'hBA);
        put(1'b0, 2'b10, 8'h07);
        chk(8'(line[1]), 8'h05);
        put(1'b0, 2'b10, lcd_pkg::CMD_SWRESET);
        chk(8'(line[1]), 8'h00);
        chk(8'(page[1]), 8'h03);
        chk(8'(col[1]), 8'h07);
        chk(8'(page[0]), 8'h01);
        put(1'b0, 2'b10, 8'h50);
        put(1'b1, 2'b10, 8'hFF);
        chk(8'(col[1]), 8'h50);
        chk(8'(col[0]), 8'h03);
        // Writes come every three cycles but drain every five, so the queue must fill.
        for (int k = 0; k < 12; k++) host_model_i.wr(1'b1, 2'b10, 8'h11);
        host_model_i.rd(1'b0, 2'b10, rdv, rdoe);
        chk(8'(rdv[7]), 8'h01);
        chk(8'(seen_busy), 8'h01);
        idle();
        chk(8'(busy), 8'h00);
        chk(8'(rdv[7]), 8'h00);
        end_sim();
    end
endmodule
